// ===== common/apmux_consts.vh
`ifndef APMUX_CONSTS_VH
`define APMUX_CONSTS_VH

// number of shared pins handled by the mux
`define APMUX_NPINS 15

// pin slot indices
`define APMUX_PIN_P3B1 0
`define APMUX_PIN_P3B2 1
`define APMUX_PIN_P3B5 4
`define APMUX_PIN_P3B6 5
`define APMUX_PIN_P3B7 6
`define APMUX_PIN_P4B0 7
`define APMUX_PIN_P4B1 8
`define APMUX_PIN_P4B2 9
`define APMUX_PIN_P4B3 10
`define APMUX_PIN_PW0 11
`define APMUX_PIN_P4B5 12
`define APMUX_PIN_P4B6 13
`define APMUX_PIN_P4B7 14

// register byte offsets
`define APMUX_OFS_MODE 8'h00
`define APMUX_OFS_PERIPH 8'h04
`define APMUX_OFS_PDATA 8'h08
`define APMUX_OFS_PDIR 8'h0C
`define APMUX_OFS_LEVEL 8'h10
`define APMUX_OFS_DRIVE 8'h14

// mode register fields
`define APMUX_MODE_EXTBUS 0
`define APMUX_MODE_MIDADR 1
`define APMUX_MODE_UPPADR 2
`define APMUX_MODE_W 3

// peripheral enable register fields
`define APMUX_PE_PGEN 0
`define APMUX_PE_RTM_LO 1
`define APMUX_PE_RTM_HI 4
`define APMUX_PE_SCKA 5
`define APMUX_PE_SCKB 6
`define APMUX_PE_SODA 7
`define APMUX_PE_SODB 8
`define APMUX_PE_RXA 9
`define APMUX_PE_RXB 10
`define APMUX_PE_EXTCLK 11
`define APMUX_PE_PWO_LO 12
`define APMUX_PE_PWO_HI 15
`define APMUX_PE_PWI_LO 16
`define APMUX_PE_PWI_HI 19
`define APMUX_PE_W 20

// reset values
`define APMUX_RST_MODE 3'h0
`define APMUX_RST_PERIPH 20'h00000
`define APMUX_RST_PINS 15'h0000
// pulse-width slot has no port bit behind it
`define APMUX_PORT_MASK 15'h77FF
// receiver slots idle high through the synchroniser
`define APMUX_SYNC_INIT 15'h0240

`endif

// ===== hw/apmux_pin_sel.v
`timescale 1ns/1ps
module apmux_pin_sel (
  input wire per_en,
  input wire per_val,
  input wire adr_en,
  input wire adr_val,
  input wire port_dir,
  input wire port_val,
  input wire susp,
  output reg drv,
  output reg val
);
  // peripheral over address over port; a receiving input holds off
  // the address drive, the port drives only when deliberately set out
  always @* begin
    drv = 1'b0;
    val = 1'b0;
    if (per_en) begin
      drv = 1'b1;
      val = per_val;
    end else if (adr_en) begin
      drv = ~susp;
      val = adr_val;
    end else if (port_dir) begin
      drv = 1'b1;
      val = port_val;
    end
  end
endmodule

// ===== hw/apmux_sync.v
`timescale 1ns/1ps
module apmux_sync #(
  parameter W = 15,
  parameter [W-1:0] INIT = {W{1'b0}}
) (
  input wire mclk,
  input wire rst,
  input wire [W-1:0] d,
  output wire [W-1:0] q
);
  reg [W-1:0] meta_r;
  reg [W-1:0] sync_r;

  // two-stage synchroniser, first stage feeds only the second
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      meta_r <= INIT;
      sync_r <= INIT;
    end else begin
      meta_r <= d;
      sync_r <= meta_r;
    end
  end

  assign q = sync_r;
endmodule

// ===== hw/apmux_top.v
`timescale 1ns/1ps
`include "apmux_consts.vh"

// What this block does
// - port3_bit1 is a port in single-chip or port mode, pulse generator off
// - external bus with middle address on drives address bit nine there
// - pulse generator output drives its pin whenever enabled
// - port3 bits two to five are ports unless their timer output or middle address mode is on
// - middle address mode drives address bits ten to thirteen
// - each reload timer channel output drives its pin when enabled
// - address bit fourteen only when clock output off; clock wins
// - clock pin a outputs clock, or feeds external clock when input
// - address bit sixteen only in upper address mode, tx a off
// - tx a data overrides port and address on its pin
// - address bit seventeen only when clock output off
// - clock pin b outputs clock, or feeds external clock when input
// - tx b drives its pin; address nineteen only when tx b off
// - upper address mode drives address bits 21 to 23 on port4 bits 5-7
// - pulse-width channel zero outputs in output mode, others off in input
// - pulse-width channels one to three likewise; input mode suspends the address drive, not the port
module apmux_top (
  input wire mclk,
  input wire rst,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output wire hreadyout,
  output wire hresp,
  output reg [31:0] hrdata,
  input wire [23:0] ext_addr_in,
  input wire pulse_gen_out,
  input wire [3:0] reload_timer_group1_outs,
  input wire serial2_clock_out,
  input wire serial2_tx_data,
  input wire pulse_width_out_ch0,
  input wire pulse_width_out_ch1,
  input wire pulse_width_out_ch2,
  input wire pulse_width_out_ch3,
  output reg serial2_ext_clk_a,
  output reg serial2_ext_clk_b,
  output reg serial2_rx_pin_a,
  output reg serial2_rx_pin_b,
  output reg pulse_width_in_ch0,
  output reg pulse_width_in_ch1,
  output reg pulse_width_in_ch2,
  output reg pulse_width_in_ch3,
  input wire [14:0] pin_in,
  output reg [14:0] pin_out,
  output reg [14:0] pin_oe_n
);
  localparam N = `APMUX_NPINS;

  // software registers and the pending write
  reg [`APMUX_MODE_W-1:0] mode_r;
  reg [`APMUX_PE_W-1:0] periph_r;
  reg [N-1:0] pdata_r;
  reg [N-1:0] pdir_r;
  reg wr_pend_r;
  reg [7:0] wr_ofs_r;

  // pin path: synchronised levels and selector results
  wire [N-1:0] pin_sync;
  wire [N-1:0] drv_w;
  wire [N-1:0] val_w;
  // per-pin requests from the function decode
  reg [N-1:0] per_en;
  reg [N-1:0] per_val;
  reg [N-1:0] adr_en;
  reg [N-1:0] adr_val;
  reg [N-1:0] susp;

  // decoded mode and enable fields
  wire ext_bus = mode_r[`APMUX_MODE_EXTBUS];
  wire mid_on = ext_bus & mode_r[`APMUX_MODE_MIDADR];
  wire upp_on = ext_bus & mode_r[`APMUX_MODE_UPPADR];
  wire [3:0] rtm_en = periph_r[`APMUX_PE_RTM_HI:`APMUX_PE_RTM_LO];
  wire [3:0] pwo_en = periph_r[`APMUX_PE_PWO_HI:`APMUX_PE_PWO_LO];
  wire [3:0] pwi_en = periph_r[`APMUX_PE_PWI_HI:`APMUX_PE_PWI_LO];
  wire sck_a_en = periph_r[`APMUX_PE_SCKA];
  wire sck_b_en = periph_r[`APMUX_PE_SCKB];
  wire sod_a_en = periph_r[`APMUX_PE_SODA];
  wire sod_b_en = periph_r[`APMUX_PE_SODB];
  wire ext_clk_mode = periph_r[`APMUX_PE_EXTCLK];
  wire [3:0] pw_out = {pulse_width_out_ch3, pulse_width_out_ch2,
                       pulse_width_out_ch1, pulse_width_out_ch0};

  // zero-wait slave, always okay
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  wire addr_phase = hsel & hready & htrans[1];

  // register window is the low 256 bytes
  function in_range;
    input [31:0] adr;
    begin
      in_range = (adr[31:8] == 24'h000000);
    end
  endfunction

  // read mux, decoded in the address phase
  // status words show the pins as synchronised and as driven
  function [31:0] reg_read;
    input [7:0] ofs;
    begin
      if (ofs == `APMUX_OFS_MODE) begin
        reg_read = {29'h00000000, mode_r};
      end else if (ofs == `APMUX_OFS_PERIPH) begin
        reg_read = {12'h000, periph_r};
      end else if (ofs == `APMUX_OFS_PDATA) begin
        reg_read = {17'h00000, pdata_r};
      end else if (ofs == `APMUX_OFS_PDIR) begin
        reg_read = {17'h00000, pdir_r};
      end else if (ofs == `APMUX_OFS_LEVEL) begin
        reg_read = {17'h00000, pin_sync};
      end else if (ofs == `APMUX_OFS_DRIVE) begin
        reg_read = {17'h00000, ~pin_oe_n};
      end else begin
        reg_read = 32'h00000000;
      end
    end
  endfunction

  // address phase capture and read data register
  // read data is taken at the address edge so it stands through the data phase
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      wr_pend_r <= 1'b0;
      wr_ofs_r <= 8'h00;
      hrdata <= 32'h00000000;
    end else if (hready) begin
      wr_pend_r <= addr_phase & hwrite & in_range(haddr);
      wr_ofs_r <= {haddr[7:2], 2'b00};
      if (addr_phase & ~hwrite & in_range(haddr)) begin
        hrdata <= reg_read({haddr[7:2], 2'b00});
      end else if (addr_phase & ~hwrite) begin
        hrdata <= 32'h00000000; // outside the window reads zero
      end
    end
  end

  // register writes in the data phase; status registers ignore writes
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      mode_r <= `APMUX_RST_MODE;
      periph_r <= `APMUX_RST_PERIPH;
      pdata_r <= `APMUX_RST_PINS;
      pdir_r <= `APMUX_RST_PINS;
    end else if (wr_pend_r) begin
      if (wr_ofs_r == `APMUX_OFS_MODE) begin
        mode_r <= hwdata[`APMUX_MODE_W-1:0];
      end else if (wr_ofs_r == `APMUX_OFS_PERIPH) begin
        periph_r <= hwdata[`APMUX_PE_W-1:0];
      end else if (wr_ofs_r == `APMUX_OFS_PDATA) begin
        pdata_r <= hwdata[N-1:0] & `APMUX_PORT_MASK;
      end else if (wr_ofs_r == `APMUX_OFS_PDIR) begin
        pdir_r <= hwdata[N-1:0] & `APMUX_PORT_MASK;
      end
    end
  end

  // pin levels enter through the synchroniser
  // receiver slots start high so reset never fakes a start bit
  apmux_sync #(
    .W(N),
    .INIT(`APMUX_SYNC_INIT)
  ) u_sync (
    .mclk(mclk),
    .rst(rst),
    .d(pin_in),
    .q(pin_sync)
  );

  // per-pin function requests
  always @* begin
    // nothing requested unless a mode or enable asks
    per_en = {N{1'b0}};
    per_val = {N{1'b0}};
    adr_en = {N{1'b0}};
    adr_val = {N{1'b0}};
    susp = {N{1'b0}};
    // port3_bit1 slot
    per_en[`APMUX_PIN_P3B1] = periph_r[`APMUX_PE_PGEN];
    per_val[`APMUX_PIN_P3B1] = pulse_gen_out;
    adr_en[`APMUX_PIN_P3B1] = mid_on;
    adr_val[`APMUX_PIN_P3B1] = ext_addr_in[9];
    // port3_bits2_5 slots
    per_en[`APMUX_PIN_P3B5:`APMUX_PIN_P3B2] = rtm_en;
    per_val[`APMUX_PIN_P3B5:`APMUX_PIN_P3B2] = reload_timer_group1_outs;
    adr_en[`APMUX_PIN_P3B5:`APMUX_PIN_P3B2] = {4{mid_on}};
    adr_val[`APMUX_PIN_P3B5:`APMUX_PIN_P3B2] = ext_addr_in[13:10];
    // port3_bit6 slot, clock pin a
    per_en[`APMUX_PIN_P3B6] = sck_a_en;
    per_val[`APMUX_PIN_P3B6] = serial2_clock_out;
    adr_en[`APMUX_PIN_P3B6] = mid_on;
    adr_val[`APMUX_PIN_P3B6] = ext_addr_in[14];
    // port3_bit7 slot, receiver pin a
    adr_en[`APMUX_PIN_P3B7] = mid_on;
    adr_val[`APMUX_PIN_P3B7] = ext_addr_in[15];
    susp[`APMUX_PIN_P3B7] = periph_r[`APMUX_PE_RXA];
    // port4_bit0 slot, tx pin a
    per_en[`APMUX_PIN_P4B0] = sod_a_en;
    per_val[`APMUX_PIN_P4B0] = serial2_tx_data;
    adr_en[`APMUX_PIN_P4B0] = upp_on;
    adr_val[`APMUX_PIN_P4B0] = ext_addr_in[16];
    // port4_bit1 slot, clock pin b
    per_en[`APMUX_PIN_P4B1] = sck_b_en;
    per_val[`APMUX_PIN_P4B1] = serial2_clock_out;
    adr_en[`APMUX_PIN_P4B1] = upp_on;
    adr_val[`APMUX_PIN_P4B1] = ext_addr_in[17];
    // port4_bit2 slot, receiver pin b
    adr_en[`APMUX_PIN_P4B2] = upp_on;
    adr_val[`APMUX_PIN_P4B2] = ext_addr_in[18];
    susp[`APMUX_PIN_P4B2] = periph_r[`APMUX_PE_RXB];
    // port4_bit3 slot, tx pin b
    per_en[`APMUX_PIN_P4B3] = sod_b_en;
    per_val[`APMUX_PIN_P4B3] = serial2_tx_data;
    adr_en[`APMUX_PIN_P4B3] = upp_on;
    adr_val[`APMUX_PIN_P4B3] = ext_addr_in[19];
    // pulse-width channel zero, no port or address behind it
    per_en[`APMUX_PIN_PW0] = pwo_en[0] & ~pwi_en[0];
    per_val[`APMUX_PIN_PW0] = pw_out[0];
    // port4_bits5_7 slots with pulse-width channels one to three
    per_en[`APMUX_PIN_P4B7:`APMUX_PIN_P4B5] = pwo_en[3:1] & ~pwi_en[3:1];
    per_val[`APMUX_PIN_P4B7:`APMUX_PIN_P4B5] = pw_out[3:1];
    adr_en[`APMUX_PIN_P4B7:`APMUX_PIN_P4B5] = {3{upp_on}};
    adr_val[`APMUX_PIN_P4B7:`APMUX_PIN_P4B5] = ext_addr_in[23:21];
    susp[`APMUX_PIN_P4B7:`APMUX_PIN_P4B5] = pwi_en[3:1];
  end

  // one priority selector per pin
  genvar gi;
  generate
    for (gi = 0; gi < N; gi = gi + 1) begin : g_pin
      apmux_pin_sel u_sel (
        .per_en(per_en[gi]),
        .per_val(per_val[gi]),
        .adr_en(adr_en[gi]),
        .adr_val(adr_val[gi]),
        .port_dir(pdir_r[gi]),
        .port_val(pdata_r[gi]),
        .susp(susp[gi]),
        .drv(drv_w[gi]),
        .val(val_w[gi])
      );
    end
  endgenerate

  // registered pin drive, released during reset
  // the register keeps selector glitches off the pins
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      pin_out <= {N{1'b0}};
      pin_oe_n <= {N{1'b1}};
    end else begin
      pin_out <= val_w;
      pin_oe_n <= ~drv_w;
    end
  end

  // external clock reaches the channel only from an input-mode pin
  function ext_clk_pick;
    input mode_on;
    input out_en;
    input dir_out;
    input lvl;
    begin
      ext_clk_pick = mode_on & ~out_en & ~dir_out & lvl;
    end
  endfunction

  // inputs handed to the peripherals from synchronised pins
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      serial2_ext_clk_a <= 1'b0;
      serial2_ext_clk_b <= 1'b0;
      serial2_rx_pin_a <= 1'b1;
      serial2_rx_pin_b <= 1'b1;
      pulse_width_in_ch0 <= 1'b0;
      pulse_width_in_ch1 <= 1'b0;
      pulse_width_in_ch2 <= 1'b0;
      pulse_width_in_ch3 <= 1'b0;
    end else begin
      serial2_ext_clk_a <= ext_clk_pick(ext_clk_mode, sck_a_en, pdir_r[`APMUX_PIN_P3B6],
                                        pin_sync[`APMUX_PIN_P3B6]);
      serial2_ext_clk_b <= ext_clk_pick(ext_clk_mode, sck_b_en, pdir_r[`APMUX_PIN_P4B1],
                                        pin_sync[`APMUX_PIN_P4B1]);
      serial2_rx_pin_a <= pin_sync[`APMUX_PIN_P3B7];
      serial2_rx_pin_b <= pin_sync[`APMUX_PIN_P4B2];
      pulse_width_in_ch0 <= pin_sync[`APMUX_PIN_PW0];
      pulse_width_in_ch1 <= pin_sync[`APMUX_PIN_P4B5];
      pulse_width_in_ch2 <= pin_sync[`APMUX_PIN_P4B6];
      pulse_width_in_ch3 <= pin_sync[`APMUX_PIN_P4B7];
    end
  end
endmodule

// ===== verif/apmux_bench.sv
`timescale 1ns/1ps
module apmux_bench;
  reg mclk, rst, hsel, hwrite, pgen, sck, sod;
  reg [31:0] haddr, hwdata, q;
  reg [1:0] htrans;
  reg [23:0] ea;
  reg [3:0] rt, pwo;
  reg [14:0] xv, xe;
  wire hro, hrs, eca, ecb, rxa, rxb;
  wire [31:0] hrdata;
  wire [14:0] pin_in, pin_out, pin_oe_n;
  wire [3:0] pwi;
  integer error_cnt, n_tests, cyc;
  apmux_top dut (.mclk(mclk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hro), .hreadyout(hro),
    .hresp(hrs), .hrdata(hrdata), .ext_addr_in(ea), .pulse_gen_out(pgen),
    .reload_timer_group1_outs(rt), .serial2_clock_out(sck), .serial2_tx_data(sod),
    .pulse_width_out_ch0(pwo[0]), .pulse_width_out_ch1(pwo[1]),
    .pulse_width_out_ch2(pwo[2]), .pulse_width_out_ch3(pwo[3]),
    .serial2_ext_clk_a(eca), .serial2_ext_clk_b(ecb), .serial2_rx_pin_a(rxa),
    .serial2_rx_pin_b(rxb), .pulse_width_in_ch0(pwi[0]), .pulse_width_in_ch1(pwi[1]),
    .pulse_width_in_ch2(pwi[2]), .pulse_width_in_ch3(pwi[3]), .pin_in(pin_in),
    .pin_out(pin_out), .pin_oe_n(pin_oe_n));
  apmux_pins far (.mclk(mclk), .pin_out(pin_out), .pin_oe_n(pin_oe_n), .ext_val(xv),
    .ext_en(xe), .pin_in(pin_in));
  // clock and hang guard
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cyc = cyc + 1;
    if (cyc == 3000) begin
      error_cnt = error_cnt + 1;
      stop_test;
    end
  end
  task stop_test;
    begin
      $display("errors %0d checks %0d", error_cnt, n_tests);
      if (error_cnt == 0 && n_tests > 0)
        $display("ALL CHECKS OK");
      else
        $display("CHECKS NOT OK");
      $finish;
    end
  endtask
  task chk(input [31:0] got, input [31:0] exp);
    begin
      n_tests = n_tests + 1;
      if (got !== exp) begin
        error_cnt = error_cnt + 1;
        $display("ERROR t=%0t got %h expected %h", $time, got, exp);
      end
    end
  endtask
  // one single-word bus transfer
  task bus(input w, input [7:0] a, input [31:0] d);
    begin
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= w;
      haddr <= {24'h000000, a};
      @(posedge mclk);
      while (hro !== 1'b1) @(posedge mclk);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      @(posedge mclk);
      while (hro !== 1'b1) @(posedge mclk);
      q = hrdata;
    end
  endtask
  task rchk(input [7:0] a, input [31:0] exp);
    begin
      bus(1'b0, a, 32'h0);
      chk(q, exp);
      chk({31'h0, hrs}, 32'h0);
    end
  endtask
  // pins settle one edge after a write lands; the check waits two
  task pchk(input [14:0] oe, input [14:0] val);
    begin
      repeat (2) @(posedge mclk);
      #1;
      chk({17'h0, pin_oe_n}, {17'h0, oe});
      chk({17'h0, pin_out & ~oe}, {17'h0, val & ~oe});
      @(posedge mclk);
    end
  endtask
  task s_reset;
    begin
      pchk(15'h7FFF, 15'h0000);
      rchk(8'h00, 32'h0);
      rchk(8'h04, 32'h0);
      bus(1'b1, 8'h18, 32'hFFFFFFFF);
      rchk(8'h18, 32'h0);
    end
  endtask
  task s_port;
    begin
      bus(1'b1, 8'h0C, 32'h7FFF);
      bus(1'b1, 8'h08, 32'h2A55);
      pchk(15'h0800, 15'h2A55);
      pgen <= 1'b0;
      rt <= 4'h5;
      bus(1'b1, 8'h04, 32'h1F);
      pchk(15'h0800, 15'h2A4A);
      bus(1'b1, 8'h14, 32'h0);
      rchk(8'h14, 32'h77FF);
    end
  endtask
  task s_mid;
    begin
      bus(1'b1, 8'h0C, 32'h0);
      bus(1'b1, 8'h04, 32'h0);
      bus(1'b1, 8'h00, 32'h6);
      pchk(15'h7FFF, 15'h0000);
      bus(1'b1, 8'h00, 32'h1);
      pchk(15'h7FFF, 15'h0000);
      bus(1'b1, 8'h00, 32'h3);
      pchk(15'h7F80, 15'h0061);
      sck <= 1'b0;
      bus(1'b1, 8'h04, 32'h20);
      pchk(15'h7F80, 15'h0041);
    end
  endtask
  task s_upper;
    begin
      bus(1'b1, 8'h04, 32'h0);
      bus(1'b1, 8'h00, 32'h5);
      pchk(15'h087F, 15'h2500);
      sod <= 1'b1;
      bus(1'b1, 8'h04, 32'h1C0);
      pchk(15'h087F, 15'h2480);
    end
  endtask
  task s_input;
    begin
      xv <= 15'h2A20;
      xe <= 15'h7FFF;
      bus(1'b1, 8'h00, 32'h7);
      bus(1'b1, 8'h04, 32'hFFE00);
      pchk(15'h7A40, 15'h0561);
      repeat (3) @(posedge mclk);
      #1;
      chk({26'h0, rxa, rxb, pwi}, 32'h15);
      @(posedge mclk);
      rchk(8'h10, 32'h2F21);
      bus(1'b1, 8'h00, 32'h0);
      bus(1'b1, 8'h04, 32'h800);
      repeat (5) @(posedge mclk);
      #1;
      chk({30'h0, eca, ecb}, 32'h2);
      @(posedge mclk);
    end
  endtask
  task s_pwout;
    begin
      pwo <= 4'h6;
      bus(1'b1, 8'h04, 32'hF000);
      pchk(15'h07FF, 15'h3000);
    end
  endtask
  // main sequence
  initial begin
    error_cnt = 0;
    n_tests = 0;
    cyc = 0;
    rst = 1'b1;
    {hsel, hwrite, htrans, haddr, hwdata, q} = 0;
    ea = 24'h5AC3F0;
    {pgen, sck, sod, rt, pwo, xv, xe} = {3'h6, 38'h0};
    repeat (10) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    s_reset;
    s_port;
    s_mid;
    s_upper;
    s_input;
    s_pwout;
    stop_test;
  end
endmodule

// ===== verif/apmux_pins.sv
`timescale 1ns/1ps
module apmux_pins (
  input wire mclk,
  input wire [14:0] pin_out,
  input wire [14:0] pin_oe_n,
  input wire [14:0] ext_val,
  input wire [14:0] ext_en,
  output wire [14:0] pin_in
);
  reg [14:0] last_r = 15'h0000;
  // undriven pins show the inverse of their last level
  always @(posedge mclk)
    last_r <= pin_in;
  // far side drives a pin only once the device has let go of it
  assign pin_in = (~pin_oe_n & pin_out) | (pin_oe_n & ext_en & ext_val)
    | (pin_oe_n & ~ext_en & ~last_r);
endmodule

// ===== verif/apmux_properties.sv
`timescale 1ns/1ps
module apmux_props (
  input wire mclk,
  input wire rst,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [31:0] hwdata,
  input wire hready,
  input wire [23:0] ext_addr_in,
  input wire pulse_gen_out,
  input wire [3:0] reload_timer_group1_outs,
  input wire serial2_clock_out,
  input wire serial2_tx_data,
  input wire [14:0] pin_out,
  input wire [14:0] pin_oe_n
);
  reg [2:0] mode_r;
  reg [19:0] pe_r;
  reg wr_r;
  reg [7:0] ofs_r;
  wire mid = mode_r[0] & mode_r[1];
  wire upp = mode_r[0] & mode_r[2];
  // shadow of mode and enable registers
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      mode_r <= 3'h0;
      pe_r <= 20'h00000;
      wr_r <= 1'b0;
      ofs_r <= 8'h00;
    end else begin
      wr_r <= hsel & hready & htrans[1] & hwrite & (haddr[31:8] == 24'h000000);
      ofs_r <= haddr[7:0];
      if (wr_r && ofs_r == 8'h00)
        mode_r <= hwdata[2:0];
      if (wr_r && ofs_r == 8'h04)
        pe_r <= hwdata[19:0];
    end
  end
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);
  pgen_pin_a: assert property (pe_r[0] |=> !pin_oe_n[0] &&
    pin_out[0] == $past(pulse_gen_out)) else $error("pulse pin wrong");
  addr9_pin_a: assert property (mid && !pe_r[0] |=> !pin_oe_n[0] &&
    pin_out[0] == $past(ext_addr_in[9])) else $error("address nine wrong");
  timer_pins_a: assert property (1'b1 |=> ($past(pe_r[4:1]) & (pin_oe_n[4:1] |
    (pin_out[4:1] ^ $past(reload_timer_group1_outs)))) == 4'h0) else $error("timer pin wrong");
  clk_pin_a: assert property (pe_r[5] |=> !pin_oe_n[5] &&
    pin_out[5] == $past(serial2_clock_out)) else $error("clock pin wrong");
  addr14_pin_a: assert property (mid && !pe_r[5] |=> !pin_oe_n[5] &&
    pin_out[5] == $past(ext_addr_in[14])) else $error("address fourteen wrong");
  tx_pin_a: assert property (pe_r[7] |=> !pin_oe_n[7] &&
    pin_out[7] == $past(serial2_tx_data)) else $error("tx pin wrong");
  addr16_pin_a: assert property (upp && !pe_r[7] |=> !pin_oe_n[7] &&
    pin_out[7] == $past(ext_addr_in[16])) else $error("address sixteen wrong");
  upper_addr_a: assert property (upp && pe_r[19:12] == 8'h00 |=> pin_oe_n[14:12] == 3'h0 &&
    pin_out[14:12] == $past(ext_addr_in[23:21])) else $error("upper address wrong");
endmodule
bind apmux_top apmux_props u_props (.mclk(mclk), .rst(rst), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
  .ext_addr_in(ext_addr_in), .pulse_gen_out(pulse_gen_out),
  .reload_timer_group1_outs(reload_timer_group1_outs), .serial2_clock_out(serial2_clock_out),
  .serial2_tx_data(serial2_tx_data), .pin_out(pin_out), .pin_oe_n(pin_oe_n));
